// ### src/sdct_pkg.sv
// sdct_pkg: constants, command codes and carrier types of the sdram
// command timing controller.
// assumes a single 50 MHz clock; times are converted to cycles here.
`default_nettype none
package sdct_pkg;

	// -------------------------------------------------------------
	// clock and speed grade
	// -------------------------------------------------------------
	localparam int CLK_NS     = 20;
	localparam bit GRADE_FAST = 1'b0;

	// -------------------------------------------------------------
	// timing limits, ns unless noted
	// -------------------------------------------------------------
	localparam int TRC_NS      = GRADE_FAST ? 75 : 100;
	localparam int TRAS_NS     = GRADE_FAST ? 45 : 60;
	localparam int TRAS_MAX_NS = 100000;
	localparam int PRECHARGE_PERIOD_NS = GRADE_FAST ? 20 : 24;
	localparam int TRCD_NS     = GRADE_FAST ? 20 : 24;
	localparam int TRRD_NS     = GRADE_FAST ? 15 : 20;
	localparam int CLOCK_ENABLE_RECOVERY_ADD_NS = 3;
	localparam int TDPL_CLK    = 2;
	localparam int TMRD_CLK    = 2;
	localparam int REF_MS      = 32;
	localparam int REF_ROWS    = 2048;
	localparam int POWER_UP_US = 200;
	localparam int INIT_REFS   = 2;
	localparam int CAS_LAT     = 2;

	// -------------------------------------------------------------
	// cycle counts: least times round up
	// -------------------------------------------------------------
	localparam int TRC_CYC  = (TRC_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRAS_CYC = (TRAS_NS + CLK_NS - 1) / CLK_NS;
	localparam int PRECHARGE_PERIOD_CYC =
		(PRECHARGE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRCD_CYC = (TRCD_NS + CLK_NS - 1) / CLK_NS;
	localparam int TRRD_CYC = (TRRD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CLOCK_ENABLE_RECOVERY_CYC =
		(CLK_NS + CLOCK_ENABLE_RECOVERY_ADD_NS + CLK_NS - 1) / CLK_NS;
	localparam int TDAL_CYC = TDPL_CLK + PRECHARGE_PERIOD_CYC;
	// longest times round down
	localparam int TRAS_MAX_CYC = TRAS_MAX_NS / CLK_NS;
	localparam int REFI_CYC =
		(REF_MS * 1000000 / CLK_NS) / REF_ROWS;
	localparam int POWER_UP_CYC = POWER_UP_US * 1000 / CLK_NS;

	// counter load values: a load of n-1 frees the command n cycles on
	localparam logic [3:0] TRC_LD  = 4'(TRC_CYC - 1);
	localparam logic [3:0] TRAS_LD = 4'(TRAS_CYC - 1);
	localparam logic [3:0] PRECHARGE_PERIOD_LD =
		4'(PRECHARGE_PERIOD_CYC - 1);
	localparam logic [3:0] TRCD_LD = 4'(TRCD_CYC - 1);
	localparam logic [3:0] TRRD_LD = 4'(TRRD_CYC - 1);
	localparam logic [3:0] CLOCK_ENABLE_RECOVERY_LD =
		4'(CLOCK_ENABLE_RECOVERY_CYC - 1);
	localparam logic [3:0] TDPL_LD = 4'(TDPL_CLK - 1);
	localparam logic [3:0] TDAL_LD = 4'(TDAL_CYC - 1);
	localparam logic [3:0] TMRD_LD = 4'(TMRD_CLK - 1);
	localparam logic [2:0] INIT_REFS_LD = 3'(INIT_REFS);
	localparam int RD_LAT = CAS_LAT + 3;

	// -------------------------------------------------------------
	// commands {cs_n, ras_n, cas_n, we_n} and mode word
	// -------------------------------------------------------------
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_RD  = 4'h5;
	localparam logic [3:0] CMD_WR  = 4'h4;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_MRS = 4'h0;
	// burst length 1, sequential, cas latency 2
	localparam logic [11:0] MODE_WORD = 12'h020;
	localparam int ADDR_BANK = 11;
	localparam int ADDR_AP   = 10;

	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POWER, ST_INIT_PRE, ST_INIT_REF, ST_INIT_MRS,
		ST_IDLE, ST_RW, ST_PRE
	} sdct_state_t;

	typedef struct packed {
		logic        write;
		logic        auto_pre;
		logic        bank;
		logic [10:0] row;
		logic [7:0]  col;
		logic [15:0] wdata;
	} sdct_req_t;

	typedef struct packed {
		logic        cke;
		logic [3:0]  cmd;
		logic [11:0] addr;
		logic [1:0]  dqm;
	} sdct_pins_t;

	typedef struct packed {
		logic [3:0] act_cnt;
		logic [3:0] rw_cnt;
		logic [3:0] pre_cnt;
	} sdct_bank_t;

	function automatic logic [3:0] sdct_max(input logic [3:0] a,
		input logic [3:0] b);
		sdct_max = (a > b) ? a : b;
	endfunction

endpackage
`default_nettype wire

// ### src/sdct_bank.sv
// sdct_bank: spacing counters of one sdram bank.
// assumes one-cycle command pulses from the controller on sys_clk.
`default_nettype none
module sdct_bank
	import sdct_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic act,
	input  wire logic rw,
	input  wire logic wr,
	input  wire logic ap,
	input  wire logic pre,
	output logic      act_ok,
	output logic      rw_ok,
	output logic      pre_ok
);

	sdct_bank_t s_ff;
	sdct_bank_t nxt_s;

	// -------------------------------------------------------------
	// counters
	// -------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		if (s_ff.act_cnt != 4'h0)
			nxt_s.act_cnt = s_ff.act_cnt - 4'h1;
		if (s_ff.rw_cnt != 4'h0)
			nxt_s.rw_cnt = s_ff.rw_cnt - 4'h1;
		if (s_ff.pre_cnt != 4'h0)
			nxt_s.pre_cnt = s_ff.pre_cnt - 4'h1;
		if (act) begin
			nxt_s.act_cnt = TRC_LD;
			nxt_s.rw_cnt  = TRCD_LD;
			nxt_s.pre_cnt = TRAS_LD;
		end
		if (rw && ap) begin
			// internal precharge waits out the active time as well
			nxt_s.act_cnt = sdct_max(nxt_s.act_cnt,
				sdct_max(nxt_s.pre_cnt + PRECHARGE_PERIOD_LD + 4'h1,
				TDAL_LD));
		end else if (rw && wr) begin
			nxt_s.pre_cnt = sdct_max(nxt_s.pre_cnt, TDPL_LD);
		end
		if (pre)
			nxt_s.act_cnt = sdct_max(nxt_s.act_cnt,
				PRECHARGE_PERIOD_LD);
	end

	always_ff @(posedge sys_clk) begin
		if (rst)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end

	assign act_ok = (s_ff.act_cnt == 4'h0);
	assign rw_ok  = (s_ff.rw_cnt == 4'h0);
	assign pre_ok = (s_ff.pre_cnt == 4'h0);

endmodule
`default_nettype wire

// ### src/sdct_ctrl.sv
// sdct_ctrl: host controller for a 2-bank 16-bit sdram; power-on
// sequence, refresh and closed-page single-word access.
// assumes dq_in comes from the pad, outside the clock domain.
`default_nettype none
module sdct_ctrl
	import sdct_pkg::*;
#(
	parameter int POWER_UP_CYCLES = POWER_UP_CYC,
	parameter int REFI_CYCLES     = REFI_CYC,
	parameter int TRAS_MAX_CYCLES = TRAS_MAX_CYC
)
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        req_valid,
	input  wire sdct_req_t   req,
	output logic             req_ready,
	output logic             init_done,
	output logic             rd_valid,
	output logic [15:0]      rd_data,
	output sdct_pins_t       pins,
	output logic [15:0]      dq_out,
	output logic             dq_oe_n,
	input  wire logic [15:0] dq_in
);

	typedef struct packed {
		sdct_state_t        st;
		logic [23:0]        wait_cnt;
		logic [23:0]        refi_cnt;
		logic               ref_pend;
		logic [3:0]         gap;
		logic [3:0]         rrd;
		logic [2:0]         init_refs;
		sdct_req_t          req;
		sdct_pins_t         pins;
		logic [15:0]        dq_out;
		logic               dq_oe_n;
		logic [RD_LAT-1:0]  rd_pipe;
		logic [15:0]        dq_s1;
		logic [15:0]        dq_s2;
		logic [15:0]        rd_data;
		logic               rd_valid;
		logic               init_done;
	} sdct_ctl_t;

	sdct_ctl_t  s_ff;
	sdct_ctl_t  nxt_s;
	logic [1:0] b_act;
	logic [1:0] b_rw;
	logic [1:0] b_pre;
	logic [1:0] act_ok;
	logic [1:0] rw_ok;
	logic [1:0] pre_ok;
	logic       can_act;
	logic       issue_rd;

	// -------------------------------------------------------------
	// per-bank timing trackers
	// -------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_bank
		sdct_bank u_bank (
			.sys_clk (sys_clk),
			.rst     (rst),
			.act     (b_act[i]),
			.rw      (b_rw[i]),
			.wr      (s_ff.req.write),
			.ap      (s_ff.req.auto_pre),
			.pre     (b_pre[i]),
			.act_ok  (act_ok[i]),
			.rw_ok   (rw_ok[i]),
			.pre_ok  (pre_ok[i])
		);
	end

	// -------------------------------------------------------------
	// command sequencing
	// -------------------------------------------------------------
	always_comb begin
		nxt_s = s_ff;
		b_act = 2'b00;
		b_rw = 2'b00;
		b_pre = 2'b00;
		issue_rd = 1'b0;
		nxt_s.pins.cmd = CMD_NOP;
		nxt_s.dq_oe_n = 1'b1;
		nxt_s.dq_s1 = dq_in;
		nxt_s.dq_s2 = s_ff.dq_s1;
		nxt_s.rd_valid = s_ff.rd_pipe[RD_LAT-1];
		if (s_ff.rd_pipe[RD_LAT-1])
			nxt_s.rd_data = s_ff.dq_s2;
		if (s_ff.wait_cnt != 24'h0000)
			nxt_s.wait_cnt = s_ff.wait_cnt - 24'h0001;
		if (s_ff.gap != 4'h0)
			nxt_s.gap = s_ff.gap - 4'h1;
		if (s_ff.rrd != 4'h0)
			nxt_s.rrd = s_ff.rrd - 4'h1;
		// refresh tick: a tick in the cycle of a refresh keeps it pending
		if (s_ff.init_done) begin
			if (s_ff.refi_cnt == 24'h0000) begin
				nxt_s.refi_cnt = 24'(REFI_CYCLES - 1);
			end else begin
				nxt_s.refi_cnt = s_ff.refi_cnt - 24'h0001;
			end
		end
		// row is closed within a few cycles of its activate, far below
		// the maximum active time, so no forced close is needed
		can_act = (s_ff.gap == 4'h0) && !s_ff.ref_pend &&
			act_ok[req.bank] && (s_ff.rrd == 4'h0);
		req_ready = (s_ff.st == ST_IDLE) && can_act;

		unique case (s_ff.st)
		ST_POWER: begin
			if (s_ff.wait_cnt == 24'h0000) begin
				nxt_s.pins.cke = 1'b1;
				nxt_s.gap = CLOCK_ENABLE_RECOVERY_LD;
				nxt_s.st = ST_INIT_PRE;
			end
		end
		ST_INIT_PRE: begin
			if (s_ff.gap == 4'h0) begin
				nxt_s.pins.cmd = CMD_PRE;
				nxt_s.pins.addr = 12'h000;
				nxt_s.pins.addr[ADDR_AP] = 1'b1;
				b_pre = 2'b11;
				nxt_s.init_refs = INIT_REFS_LD;
				nxt_s.st = ST_INIT_REF;
			end
		end
		ST_INIT_REF: begin
			if (s_ff.gap == 4'h0 && act_ok == 2'b11) begin
				nxt_s.pins.cmd = CMD_REF;
				nxt_s.gap = TRC_LD;
				nxt_s.init_refs = s_ff.init_refs - 3'h1;
				if (s_ff.init_refs == 3'h1)
					nxt_s.st = ST_INIT_MRS;
			end
		end
		ST_INIT_MRS: begin
			if (s_ff.gap == 4'h0) begin
				nxt_s.pins.cmd = CMD_MRS;
				nxt_s.pins.addr = MODE_WORD;
				nxt_s.gap = TMRD_LD;
				nxt_s.init_done = 1'b1;
				nxt_s.refi_cnt = 24'(REFI_CYCLES - 1);
				nxt_s.st = ST_IDLE;
			end
		end
		ST_IDLE: begin
			if (s_ff.ref_pend && s_ff.gap == 4'h0 &&
				act_ok == 2'b11) begin
				nxt_s.pins.cmd = CMD_REF;
				nxt_s.gap = TRC_LD;
				nxt_s.ref_pend = 1'b0;
			end else if (req_valid && can_act) begin
				nxt_s.req = req;
				nxt_s.pins.cmd = CMD_ACT;
				nxt_s.pins.addr = {req.bank, req.row};
				b_act[req.bank] = 1'b1;
				nxt_s.rrd = TRRD_LD;
				nxt_s.st = ST_RW;
			end
		end
		ST_RW: begin
			if (rw_ok[s_ff.req.bank]) begin
				nxt_s.pins.cmd = s_ff.req.write ? CMD_WR : CMD_RD;
				nxt_s.pins.addr = {s_ff.req.bank, s_ff.req.auto_pre,
					2'b00, s_ff.req.col};
				b_rw[s_ff.req.bank] = 1'b1;
				if (s_ff.req.write) begin
					nxt_s.dq_out = s_ff.req.wdata;
					nxt_s.dq_oe_n = 1'b0;
				end else begin
					issue_rd = 1'b1;
				end
				nxt_s.st = s_ff.req.auto_pre ? ST_IDLE : ST_PRE;
			end
		end
		ST_PRE: begin
			if (pre_ok[s_ff.req.bank]) begin
				nxt_s.pins.cmd = CMD_PRE;
				nxt_s.pins.addr = 12'h000;
				nxt_s.pins.addr[ADDR_BANK] = s_ff.req.bank;
				b_pre[s_ff.req.bank] = 1'b1;
				nxt_s.st = ST_IDLE;
			end
		end
		endcase

		if (s_ff.init_done && s_ff.refi_cnt == 24'h0000)
			nxt_s.ref_pend = 1'b1;
		nxt_s.rd_pipe = {s_ff.rd_pipe[RD_LAT-2:0], issue_rd};
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_ff <= '0;
			s_ff.wait_cnt <= 24'(POWER_UP_CYCLES - 1);
			s_ff.pins.cmd <= CMD_NOP;
			s_ff.dq_oe_n <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// -------------------------------------------------------------
	// outputs
	// -------------------------------------------------------------
	assign pins      = s_ff.pins;
	assign dq_out    = s_ff.dq_out;
	assign dq_oe_n   = s_ff.dq_oe_n;
	assign rd_data   = s_ff.rd_data;
	assign rd_valid  = s_ff.rd_valid;
	assign init_done = s_ff.init_done;

endmodule
`default_nettype wire

// ### sim/sdct_props.sv
// sdct_props: command spacing checks on the pins of sdct_ctrl.
// assumes sys_clk only and the synchronous reset rst.
`default_nettype none
module sdct_props
	import sdct_pkg::*;
#(
	parameter int REFI_CYCLES = REFI_CYC
)
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       init_done,
	input wire sdct_pins_t pins
);
	// ---------------------------------------------------------------
	// cycles since activate, precharge, auto precharge write and refresh, saturating at 15; gap counts from refresh
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0][3:0] act;
		logic [1:0][3:0] pre;
		logic [1:0][3:0] apw;
		logic [3:0]      rf;
		logic [11:0]     gap;
	} sdct_chk_t;
	sdct_chk_t chk_ff;
	sdct_chk_t nxt_chk;
	wire logic bk     = pins.addr[11];
	wire logic is_act = pins.cmd == CMD_ACT;
	wire logic is_pre = pins.cmd == CMD_PRE;
	wire logic is_ref = pins.cmd == CMD_REF;
	wire logic is_wr  = pins.cmd == CMD_WR;
	wire logic is_col = is_wr || pins.cmd == CMD_RD;
	wire logic is_nop = pins.cmd == CMD_NOP;

	function automatic logic [3:0] step(input logic hit,
		input logic [3:0] c);
		step = hit ? 4'h1 : ((c == 4'hf) ? c : c + 4'h1);
	endfunction

	always_comb begin
		nxt_chk = chk_ff;
		for (int k = 0; k < 2; k++) begin
			nxt_chk.act[k] = step(is_act && bk == k, chk_ff.act[k]);
			nxt_chk.pre[k] = step(is_pre && (bk == k || pins.addr[10]),
				chk_ff.pre[k]);
			nxt_chk.apw[k] = step(is_wr && pins.addr[10] && bk == k,
				chk_ff.apw[k]);
		end
		nxt_chk.rf = step(is_ref, chk_ff.rf);
		// gap only grows once the part is in service
		nxt_chk.gap = (is_ref || !init_done) ? 12'h000
			: chk_ff.gap + 12'h001;
	end

	always_ff @(posedge sys_clk) begin
		chk_ff <= rst ? '1 : nxt_chk;
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_act_same_bank: assert property (is_act |->
		chk_ff.act[bk] >= 4'(TRC_CYC) && chk_ff.rf >= 4'(TRC_CYC))
		else $error("activate too soon after activate or refresh");
	a_ref_spacing: assert property (is_ref |-> chk_ff.rf >= 4'(TRC_CYC)
		&& chk_ff.apw[0] >= 4'(TDAL_CYC) && chk_ff.apw[1] >= 4'(TDAL_CYC))
		else $error("refresh too soon");
	a_act_to_pre: assert property (is_act |=> (!is_pre) [*2])
		else $error("precharge before active time");
	a_pre_to_act: assert property (is_act |->
		chk_ff.pre[bk] >= 4'(PRECHARGE_PERIOD_CYC))
		else $error("activate inside precharge period");
	a_act_to_col: assert property (is_act |=> !is_col)
		else $error("column command before row delay");
	a_wr_recovery: assert property (is_wr |=> !is_pre)
		else $error("precharge inside write recovery");
	a_wr_ap_wait: assert property (is_act |->
		chk_ff.apw[bk] >= 4'(TDAL_CYC))
		else $error("activate too soon after auto precharge write");
	a_refresh_due: assert property (init_done |->
		chk_ff.gap < 12'(REFI_CYCLES + 24))
		else $error("refresh overdue");
	a_cke_recovery: assert property ($rose(pins.cke) |-> is_nop [*2])
		else $error("command inside clock enable recovery");
	a_init_first: assert property (!init_done |-> !(is_act || is_col))
		else $error("access before initialisation");
	a_mode_gap: assert property (pins.cmd == CMD_MRS |=> is_nop)
		else $error("command inside mode set delay");
endmodule
bind sdct_ctrl sdct_props #(
	.REFI_CYCLES(REFI_CYCLES)
) props_u (
	.sys_clk  (sys_clk),
	.rst      (rst),
	.init_done(init_done),
	.pins     (pins)
);
`default_nettype wire

// ### sim/sdct_dev_model.sv
// sdct_dev_model: behavioural sdram on the far side of sdct_ctrl.
// assumes burst length 1, cas latency 2; no reset pin, as on the part.
`default_nettype none
module sdct_dev_model
	import sdct_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire sdct_pins_t  pins,
	input  wire logic [15:0] dq,
	input  wire logic        dq_oe_n,
	output logic [15:0]      dq_in,
	output logic             fault
);
	logic [15:0] mem [32];
	logic [1:0]  open_ff = 2'h0;
	logic        mode_ff = 1'h0;
	logic        bad     = 1'h0;
	logic [1:0]  rd_p    = 2'h0;
	logic [4:0]  ra0;
	logic [4:0]  ra1;
	logic [15:0] held    = 16'h0000;
	wire logic [4:0] idx = {pins.addr[11], pins.addr[3:0]};
	wire logic live = pins.cke;
	wire logic col  = live && (pins.cmd == CMD_RD || pins.cmd == CMD_WR);
	// released bus flips every cycle so stale data never matches
	assign dq_in = rd_p[1] ? mem[ra1] : ~held;
	assign fault = bad;

	always @(posedge sys_clk) begin
		held <= dq_in;
		rd_p <= {rd_p[0], live && pins.cmd == CMD_RD};
		ra0  <= idx;
		ra1  <= ra0;
		if (live && pins.cmd == CMD_MRS)
			mode_ff <= 1'h1;
		if (live && pins.cmd == CMD_ACT)
			open_ff[pins.addr[11]] <= 1'h1;
		if (live && pins.cmd == CMD_PRE && pins.addr[10])
			open_ff <= 2'h0;
		else if (live && (pins.cmd == CMD_PRE || (col && pins.addr[10])))
			open_ff[pins.addr[11]] <= 1'h0;
		if (col && !open_ff[pins.addr[11]])
			bad <= 1'h1;
		if ((col || pins.cmd == CMD_ACT) && !mode_ff)
			bad <= 1'h1;
		if (live && pins.cmd == CMD_REF && open_ff != 2'h0)
			bad <= 1'h1;
		if (live && pins.cmd == CMD_WR && dq_oe_n)
			bad <= 1'h1;
		if (live && pins.cmd == CMD_WR && !dq_oe_n)
			mem[idx] <= dq;
	end
endmodule
`default_nettype wire

// ### sim/sdct_ctrl_bench.sv
// sdct_ctrl_bench: self-checking bench for sdct_ctrl.
// assumes sdct_dev_model as the memory; short power-up and refresh.
`default_nettype none
module sdct_ctrl_bench
	import sdct_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PU = 20;
	logic        sys_clk   = 1'h0;
	logic        rst       = 1'h1;
	logic        req_valid = 1'h0;
	sdct_req_t   req       = '0;
	logic        req_ready;
	logic        init_done;
	logic        rd_valid;
	logic        dq_oe_n;
	logic        fault;
	logic [15:0] rd_data;
	logic [15:0] dq_out;
	logic [15:0] dq_in;
	logic [11:0] mrs_addr;
	sdct_pins_t  pins;
	int          err_total  = 0;
	int          n_compared = 0;
	int          n_ref      = 0;

	sdct_ctrl #(.POWER_UP_CYCLES(PU), .REFI_CYCLES(40)) dut_u (
		.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .init_done(init_done),
		.rd_valid(rd_valid), .rd_data(rd_data), .pins(pins),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
	sdct_dev_model mdl_u (.sys_clk(sys_clk), .pins(pins), .dq(dq_out),
		.dq_oe_n(dq_oe_n), .dq_in(dq_in), .fault(fault));

	initial forever #10 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		if (pins.cmd == CMD_REF)
			n_ref <= n_ref + 1;
		if (pins.cmd == CMD_MRS)
			mrs_addr <= pins.addr;
	end

	task automatic tally_and_finish;
		if (err_total == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t ns: %h not %h", $time, got, exp);
		end
	endtask

	task automatic bail(input int i);
		if (i >= 99) begin
			err_total++;
			tally_and_finish();
		end
	endtask

	task automatic issue(input sdct_req_t r);
		int i;
		req = r;
		req_valid = 1'h1;
		for (i = 0; i < 99; i++) begin
			#1;
			if (req_ready === 1'h1)
				break;
			@(negedge sys_clk);
		end
		bail(i);
		@(negedge sys_clk);
		req_valid = 1'h0;
	endtask

	task automatic access(input logic w, input logic ap, input logic b,
		input logic [7:0] col, input logic [15:0] d);
		issue({w, ap, b, 11'h2c3, col, d});
		chk(pins.cmd, CMD_ACT);
		chk(pins.addr, {b, 11'h2c3});
		repeat (2) @(negedge sys_clk);
		chk(pins.cmd, w ? CMD_WR : CMD_RD);
		chk(pins.addr, {b, ap, 2'h0, col});
		if (w) begin
			chk(dq_out, d);
			chk(dq_oe_n, 1'h0);
			chk(pins.dqm, 2'h0);
			@(negedge sys_clk);
			chk(pins.cmd, CMD_NOP);
			chk(dq_oe_n, 1'h1);
			if (!ap) begin
				@(negedge sys_clk);
				chk(pins.cmd, CMD_PRE);
				chk(pins.addr, {b, 11'h000});
			end
		end else begin
			@(negedge sys_clk);
			chk(pins.cmd, ap ? CMD_NOP : CMD_PRE);
			repeat (3) @(negedge sys_clk);
			chk(rd_valid, 1'h0);
			@(negedge sys_clk);
			chk(rd_valid, 1'h1);
			chk(rd_data, d);
		end
	endtask

	task automatic t_reset;
		rst = 1'h1;
		repeat (4) @(negedge sys_clk);
		chk(pins.cke, 1'h0);
		chk(pins.cmd, CMD_NOP);
		chk(dq_oe_n, 1'h1);
		chk(init_done, 1'h0);
		chk(req_ready, 1'h0);
		rst = 1'h0;
	endtask

	task automatic t_power_up;
		int i;
		int base;
		base = n_ref;
		for (i = 0; i < 99 && pins.cke !== 1'h1; i++)
			@(negedge sys_clk);
		bail(i);
		chk(16'(i), 16'(PU));
		for (i = 0; i < 99 && init_done !== 1'h1; i++)
			@(negedge sys_clk);
		bail(i);
		@(negedge sys_clk);
		chk(16'(n_ref - base), 16'(INIT_REFS));
		chk(mrs_addr, MODE_WORD);
	endtask

	// same bank back to back, then auto precharge, then reads
	task automatic t_traffic;
		access(1'h1, 1'h0, 1'h0, 8'h03, 16'hbeef);
		access(1'h1, 1'h0, 1'h0, 8'h04, 16'h1234);
		access(1'h1, 1'h1, 1'h1, 8'h03, 16'hc0de);
		access(1'h0, 1'h0, 1'h0, 8'h03, 16'hbeef);
		access(1'h0, 1'h1, 1'h1, 8'h03, 16'hc0de);
		access(1'h0, 1'h0, 1'h0, 8'h04, 16'h1234);
	endtask

	task automatic t_refresh;
		int base;
		base = n_ref;
		repeat (200) @(negedge sys_clk);
		chk(16'(n_ref - base >= 4), 16'h0001);
		access(1'h0, 1'h0, 1'h1, 8'h03, 16'hc0de);
	endtask

	initial begin
		t_reset();
		t_power_up();
		t_traffic();
		t_refresh();
		// second reset: the part keeps its data across it
		t_reset();
		t_power_up();
		access(1'h0, 1'h1, 1'h0, 8'h04, 16'h1234);
		chk(fault, 1'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
